// ### core/blsm_alu.sv
// Combinational operation unit computing the result byte and carry for one instruction.
`timescale 1ns/1ns
`default_nettype none
module blsm_alu (
  input  wire blsm_pkg::blsm_op_t    op_i,
  input  wire logic [7:0]            acc_i,
  input  wire logic [7:0]            file_i,
  output var blsm_pkg::blsm_alu_t    res_o
);

  always_comb begin
    res_o = '0;
    case (op_i)
      blsm_pkg::BLSM_OR_ACC_WITH_FILE: begin
        res_o.result = acc_i | file_i;
      end
      blsm_pkg::BLSM_SHIFT_LEFT_FILE: begin
        res_o.result    = {file_i[6:0], 1'b0};
        res_o.carry     = file_i[blsm_pkg::MSB_POS];
        res_o.carry_hit = 1'b1;
      end
      blsm_pkg::BLSM_SHIFT_RIGHT_FILE: begin
        res_o.result    = {1'b0, file_i[7:1]};
        res_o.carry     = file_i[blsm_pkg::LSB_POS];
        res_o.carry_hit = 1'b1;
      end
      blsm_pkg::BLSM_MOVE_FILE_REG: begin
        res_o.result = file_i;
      end
      default: begin
        res_o = '0;
      end
    endcase
  end

endmodule
`default_nettype wire

// ### core/blsm_core.sv
// Top of the byte logic, shift and move datapath with accumulator, flags and file write port.
//
// Summary of operation
// - OR accumulator with file register; zero flag follows the result.
// - Destination 0 writes OR result to accumulator, 1 writes file register.
// - Left shift: bit 7 to carry, bits 6..0 up, zero into bit 0.
// - Right shift: zero into bit 7, bits 7..1 down, bit 0 to carry.
// - Shift result goes to accumulator on destination 0, file on 1.
// - Move copies file register unchanged to accumulator or back to itself.
// - Move updates zero flag even when writing back to its own register.
`timescale 1ns/1ns
`default_nettype none
module blsm_core (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire blsm_pkg::blsm_req_t   req_i,
  output logic [7:0]                 acc_o,
  output logic                       zero_o,
  output logic                       carry_o,
  output var blsm_pkg::blsm_wr_t     file_wr_o,
  output logic                       done_o
);

  blsm_pkg::blsm_alu_t alu_res;
  logic [7:0]          acc_ff;
  logic [7:0]          nxt_acc;
  logic                zero_ff;
  logic                nxt_zero;
  logic                carry_ff;
  logic                nxt_carry;
  blsm_pkg::blsm_wr_t  file_wr_ff;
  blsm_pkg::blsm_wr_t  nxt_file_wr;
  logic                done_ff;

  blsm_alu u_alu (
    .op_i   (req_i.op),
    .acc_i  (acc_ff),
    .file_i (req_i.file_data),
    .res_o  (alu_res)
  );

  // The accumulator changes only when the destination selects it.
  always_comb begin
    nxt_acc = acc_ff;
    if (req_i.valid && (req_i.dest == blsm_pkg::DEST_ACC)) begin
      nxt_acc = alu_res.result;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_ff <= blsm_pkg::ACC_RST;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // Every operation here affects the zero flag, whatever the destination.
  always_comb begin
    nxt_zero = zero_ff;
    if (req_i.valid) begin
      nxt_zero = (alu_res.result == 8'h00);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zero_ff <= blsm_pkg::FLAG_RST;
    end else begin
      zero_ff <= nxt_zero;
    end
  end

  // Only the two shifts move carry; OR and move leave it as it was.
  always_comb begin
    nxt_carry = carry_ff;
    if (req_i.valid && alu_res.carry_hit) begin
      nxt_carry = alu_res.carry;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      carry_ff <= blsm_pkg::FLAG_RST;
    end else begin
      carry_ff <= nxt_carry;
    end
  end

  // The file registers live outside this block, so the result leaves on a write port
  // that is valid for one cycle and that the caller applies.
  always_comb begin
    nxt_file_wr       = '0;
    nxt_file_wr.valid = req_i.valid && (req_i.dest == blsm_pkg::DEST_FILE);
    nxt_file_wr.addr  = req_i.addr;
    nxt_file_wr.data  = alu_res.result;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      file_wr_ff <= '0;
    end else begin
      file_wr_ff <= nxt_file_wr;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= req_i.valid;
    end
  end

  assign acc_o     = acc_ff;
  assign zero_o    = zero_ff;
  assign carry_o   = carry_ff;
  assign file_wr_o = file_wr_ff;
  assign done_o    = done_ff;

  // Each check looks one cycle after the request edge, when the answer first stands.
  a_or_result: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.op == blsm_pkg::BLSM_OR_ACC_WITH_FILE && !req_i.dest)
      |=> (acc_o == ($past(acc_o) | $past(req_i.file_data))))
    else $error("OR result wrong in accumulator");

  a_dest_file_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.dest) |=> (file_wr_o.valid && $stable(acc_o)
      && file_wr_o.addr == $past(req_i.addr)))
    else $error("file destination not honoured");

  a_shl_carry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.op == blsm_pkg::BLSM_SHIFT_LEFT_FILE && req_i.dest)
      |=> (carry_o == $past(req_i.file_data[7])
        && file_wr_o.data == {$past(req_i.file_data[6:0]), 1'b0}))
    else $error("left shift wrong");

  a_shr_carry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.op == blsm_pkg::BLSM_SHIFT_RIGHT_FILE && !req_i.dest)
      |=> (carry_o == $past(req_i.file_data[0])
        && acc_o == {1'b0, $past(req_i.file_data[7:1])}))
    else $error("right shift wrong");

  a_shift_dest_acc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.op inside {blsm_pkg::BLSM_SHIFT_LEFT_FILE,
      blsm_pkg::BLSM_SHIFT_RIGHT_FILE} && !req_i.dest) |=> !file_wr_o.valid)
    else $error("shift to accumulator also wrote file");

  a_move_copy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.op == blsm_pkg::BLSM_MOVE_FILE_REG)
      |=> ($past(req_i.dest) ? (file_wr_o.data == $past(req_i.file_data))
        : (acc_o == $past(req_i.file_data))))
    else $error("move did not copy value");

  a_move_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.op == blsm_pkg::BLSM_MOVE_FILE_REG && req_i.dest)
      |=> (zero_o == ($past(req_i.file_data) == 8'h00)) && $stable(carry_o))
    else $error("move zero flag wrong");

  a_one_cycle_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_i.valid |=> (done_o && file_wr_o.valid == $past(req_i.dest)))
    else $error("operation not done in one cycle");

  a_or_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.op == blsm_pkg::BLSM_OR_ACC_WITH_FILE)
      |=> (zero_o == (($past(acc_o) | $past(req_i.file_data)) == 8'h00)))
    else $error("OR zero flag wrong");

  a_or_to_file: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.op == blsm_pkg::BLSM_OR_ACC_WITH_FILE && req_i.dest)
      |=> (file_wr_o.valid && $stable(acc_o)
        && file_wr_o.data == ($past(acc_o) | $past(req_i.file_data))))
    else $error("OR result wrong on file write port");

  a_acc_dest_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && !req_i.dest) |=> !file_wr_o.valid)
    else $error("accumulator destination also wrote file");

  a_shl_to_acc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.op == blsm_pkg::BLSM_SHIFT_LEFT_FILE && !req_i.dest)
      |=> (carry_o == $past(req_i.file_data[7])
        && acc_o == {$past(req_i.file_data[6:0]), 1'b0}))
    else $error("left shift into accumulator wrong");

  a_shl_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.op == blsm_pkg::BLSM_SHIFT_LEFT_FILE)
      |=> (zero_o == ($past(req_i.file_data[6:0]) == 7'h00)))
    else $error("left shift zero flag wrong");

  a_shr_to_file: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.op == blsm_pkg::BLSM_SHIFT_RIGHT_FILE && req_i.dest)
      |=> (file_wr_o.valid && carry_o == $past(req_i.file_data[0])
        && file_wr_o.data == {1'b0, $past(req_i.file_data[7:1])}))
    else $error("right shift into file wrong");

  a_shr_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.op == blsm_pkg::BLSM_SHIFT_RIGHT_FILE)
      |=> (zero_o == ($past(req_i.file_data[7:1]) == 7'h00)))
    else $error("right shift zero flag wrong");

  a_shift_to_file: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.op inside {blsm_pkg::BLSM_SHIFT_LEFT_FILE,
      blsm_pkg::BLSM_SHIFT_RIGHT_FILE} && req_i.dest) |=> (file_wr_o.valid && $stable(acc_o)))
    else $error("shift to file also changed accumulator");

  a_carry_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.op inside {blsm_pkg::BLSM_OR_ACC_WITH_FILE,
      blsm_pkg::BLSM_MOVE_FILE_REG}) |=> $stable(carry_o))
    else $error("carry changed by OR or move");

  a_move_acc_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.op == blsm_pkg::BLSM_MOVE_FILE_REG && !req_i.dest)
      |=> (zero_o == ($past(req_i.file_data) == 8'h00)))
    else $error("move to accumulator zero flag wrong");

  a_idle_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !req_i.valid |=> (!done_o && !file_wr_o.valid && $stable(acc_o)
      && $stable(zero_o) && $stable(carry_o)))
    else $error("state changed without a request");

endmodule
`default_nettype wire

// ### core/blsm_pkg.sv
// Package with opcodes, widths and reset values for the byte logic, shift and move datapath.
package blsm_pkg;

  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 7;
  localparam int unsigned MSB_POS  = 7;
  localparam int unsigned LSB_POS  = 0;

  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic       FLAG_RST  = 1'b0;
  localparam logic       DEST_ACC  = 1'b0;
  localparam logic       DEST_FILE = 1'b1;

  typedef enum logic [1:0] {
    BLSM_OR_ACC_WITH_FILE  = 2'b00,
    BLSM_SHIFT_LEFT_FILE   = 2'b01,
    BLSM_SHIFT_RIGHT_FILE  = 2'b10,
    BLSM_MOVE_FILE_REG     = 2'b11
  } blsm_op_t;

  typedef struct packed {
    logic                   valid;
    blsm_op_t               op;
    logic                   dest;
    logic [ADDR_W-1:0]      addr;
    logic [DATA_W-1:0]      file_data;
  } blsm_req_t;

  typedef struct packed {
    logic                   valid;
    logic [ADDR_W-1:0]      addr;
    logic [DATA_W-1:0]      data;
  } blsm_wr_t;

  typedef struct packed {
    logic [DATA_W-1:0]      result;
    logic                   carry;
    logic                   carry_hit;
  } blsm_alu_t;

endpackage

// ### test/blsm_tb.sv
// Self-checking testbench for the byte logic, shift and move datapath.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic                clk_i;
  logic                rst_n_i;
  blsm_pkg::blsm_req_t req;
  logic [7:0]          acc;
  logic                zero;
  logic                carry;
  blsm_pkg::blsm_wr_t  wr;
  logic                done;
  logic [7:0]          exp_acc;
  logic                exp_c;
  int                  errors;
  int                  comparisons;

  blsm_core blsm_core_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .acc_o(acc),
    .zero_o(zero), .carry_o(carry), .file_wr_o(wr), .done_o(done));

  always #25 clk_i = ~clk_i;

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask

  // Issues one instruction and checks every output one cycle after it is issued, the write data and address only for destination 1.
  task automatic run(input blsm_pkg::blsm_op_t o, input logic d, input logic [7:0] f,
                     input logic [7:0] r, input logic c);
    @(posedge clk_i);
    req <= '{1'b1, o, d, 7'h2A, f};
    @(posedge clk_i);
    req.valid <= 1'b0;
    #1;
    if (d == blsm_pkg::DEST_ACC) exp_acc = r;
    exp_c = c;
    chk("done", {7'h00, done}, 8'h01);
    chk("acc", acc, exp_acc);
    chk("carry", {7'h00, carry}, {7'h00, c});
    chk("zero", {7'h00, zero}, {7'h00, r == 8'h00});
    chk("wr_valid", {7'h00, wr.valid}, {7'h00, d});
    if (d) begin
      chk("wr_data", wr.data, r);
      chk("wr_addr", {1'b0, wr.addr}, 8'h2A);
    end
    @(posedge clk_i);
    #1;
    chk("done_end", {7'h00, done}, 8'h00);
    chk("wr_end", {7'h00, wr.valid}, 8'h00);
    chk("acc_hold", acc, exp_acc);
  endtask

  task automatic t_reset;
    #1;
    chk("rst_acc", acc, blsm_pkg::ACC_RST);
    chk("rst_flags", {5'h00, zero, carry, done}, 8'h00);
    chk("rst_wr", {7'h00, wr.valid}, 8'h00);
  endtask

  task automatic t_shl;
    run(blsm_pkg::BLSM_SHIFT_LEFT_FILE, 1'b1, 8'h81, 8'h02, 1'b1);
    run(blsm_pkg::BLSM_SHIFT_LEFT_FILE, 1'b0, 8'h7F, 8'hFE, 1'b0);
    run(blsm_pkg::BLSM_SHIFT_LEFT_FILE, 1'b0, 8'h80, 8'h00, 1'b1);
  endtask

  // Carry must survive the OR and move instructions untouched.
  task automatic t_or;
    run(blsm_pkg::BLSM_OR_ACC_WITH_FILE, 1'b0, 8'h10, exp_acc | 8'h10, exp_c);
    run(blsm_pkg::BLSM_OR_ACC_WITH_FILE, 1'b1, 8'h44, exp_acc | 8'h44, exp_c);
    run(blsm_pkg::BLSM_MOVE_FILE_REG, 1'b0, 8'h00, 8'h00, exp_c);
    run(blsm_pkg::BLSM_OR_ACC_WITH_FILE, 1'b1, 8'h81, exp_acc | 8'h81, exp_c);
    run(blsm_pkg::BLSM_OR_ACC_WITH_FILE, 1'b0, 8'h00, 8'h00, exp_c);
  endtask

  task automatic t_shr;
    run(blsm_pkg::BLSM_SHIFT_RIGHT_FILE, 1'b0, 8'h01, 8'h00, 1'b1);
    run(blsm_pkg::BLSM_SHIFT_RIGHT_FILE, 1'b1, 8'hFE, 8'h7F, 1'b0);
    run(blsm_pkg::BLSM_SHIFT_RIGHT_FILE, 1'b0, 8'h03, 8'h01, 1'b1);
  endtask

  task automatic t_mov;
    run(blsm_pkg::BLSM_MOVE_FILE_REG, 1'b1, 8'h00, 8'h00, exp_c);
    run(blsm_pkg::BLSM_MOVE_FILE_REG, 1'b0, 8'hA5, 8'hA5, exp_c);
    run(blsm_pkg::BLSM_MOVE_FILE_REG, 1'b1, 8'h3C, 8'h3C, exp_c);
  endtask

  // Two requests on consecutive edges: the OR must see the accumulator just moved in.
  task automatic t_b2b;
    @(posedge clk_i);
    req <= '{1'b1, blsm_pkg::BLSM_MOVE_FILE_REG, blsm_pkg::DEST_ACC, 7'h11, 8'h0F};
    @(posedge clk_i);
    req <= '{1'b1, blsm_pkg::BLSM_OR_ACC_WITH_FILE, blsm_pkg::DEST_ACC, 7'h12, 8'hF0};
    #1;
    chk("b2b_mov", acc, 8'h0F);
    @(posedge clk_i);
    req.valid <= 1'b0;
    #1;
    exp_acc = 8'hFF;
    chk("b2b_acc", acc, exp_acc);
    chk("b2b_done", {7'h00, done}, 8'h01);
    chk("b2b_carry", {7'h00, carry}, {7'h00, exp_c});
  endtask

  // Reset in mid-run clears every register at once, without waiting for an edge.
  task automatic t_mid_reset;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    t_reset();
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    exp_acc = blsm_pkg::ACC_RST;
    exp_c = blsm_pkg::FLAG_RST;
  endtask

  task automatic final_report;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    req = '0;
    errors = 0;
    comparisons = 0;
    exp_acc = blsm_pkg::ACC_RST;
    exp_c = blsm_pkg::FLAG_RST;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_shl();
    t_or();
    t_b2b();
    t_mid_reset();
    t_shr();
    t_mov();
    final_report();
  end
endmodule
`default_nettype wire
